/* File: core/output_fault_supervisor.sv */
// output fault supervisor: undervoltage, overvoltage, tracking and
// overtemperature protection, overtemperature warning and power-good pin.
// assumes measurement words are synchronous to ref_clk and already scaled
`default_nettype none
module output_fault_supervisor #(
	parameter int unsigned OT_DELAY_CYC = fault_sup_pkg::OT_CYC,
	parameter int unsigned RETRY_DELAY_CYC = fault_sup_pkg::RETRY_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [fault_sup_pkg::MV_W-1:0] vout_mv,
	input wire logic [fault_sup_pkg::MV_W-1:0] vset_mv,
	input wire logic [fault_sup_pkg::MV_W-1:0] ramp_target_mv,
	input wire logic ramping,
	input wire logic [fault_sup_pkg::TEMP_W-1:0] temp_c,
	input wire logic [1:0] uv_pct_sel,
	input wire logic [1:0] ov_pct_sel,
	input wire logic pg_lo_sel,
	input wire logic uv_latch_en,
	input wire logic ot_latch_en,
	input wire logic ov_latch_en,
	input wire logic trk_en,
	input wire logic trk_latch_en,
	input wire logic fault_clear,
	output logic turn_off,
	output logic ot_warning,
	output logic power_good_out,
	output logic undervoltage_trip,
	output logic overvoltage_trip,
	output logic tracking_trip,
	output logic ot_trip,
	output logic fault_latched
);
	localparam int unsigned RETRY_W = $clog2(RETRY_DELAY_CYC + 1);
	localparam logic [RETRY_W-1:0] RETRY_LAST = RETRY_W'(RETRY_DELAY_CYC - 1);
	localparam logic [7:0] UV_PCT_MAX = 8'd90;

	qual_if uv_c ();
	qual_if ov_c ();
	qual_if trk_c ();
	qual_if ot_c ();
	qual_if warn_c ();
	qual_if pg_c ();

	// percentage thresholds compared as vout*100 against vset*pct, no divider needed
	wire [7:0] uv_pct_raw = fault_sup_pkg::UV_PCT_BASE
		+ 8'(fault_sup_pkg::UV_PCT_STEP * uv_pct_sel);
	wire [7:0] uv_pct = (uv_pct_raw > UV_PCT_MAX) ? UV_PCT_MAX : uv_pct_raw;
	wire [7:0] ov_pct_raw = fault_sup_pkg::OV_PCT_BASE
		+ 8'(fault_sup_pkg::OV_PCT_STEP * ov_pct_sel);
	wire [7:0] ov_pct = (ov_pct_raw > fault_sup_pkg::OV_PCT_MAX)
		? fault_sup_pkg::OV_PCT_MAX : ov_pct_raw;
	wire [7:0] pg_lo_pct = fault_sup_pkg::PG_LO_PCT_BASE
		+ (pg_lo_sel ? fault_sup_pkg::PG_LO_PCT_STEP : 8'h00);
	// widen before multiplying: a cast of the product would keep only twelve bits
	wire [fault_sup_pkg::PROD_W-1:0] vout_w = fault_sup_pkg::PROD_W'(vout_mv);
	wire [fault_sup_pkg::PROD_W-1:0] vset_w = fault_sup_pkg::PROD_W'(vset_mv);
	wire [fault_sup_pkg::PROD_W-1:0] vout_x100 = vout_w * fault_sup_pkg::PCT_SCALE;
	wire [fault_sup_pkg::PROD_W-1:0] uv_lim = vset_w * uv_pct;
	wire [fault_sup_pkg::PROD_W-1:0] ov_pct_lim = vset_w * ov_pct;
	wire [fault_sup_pkg::PROD_W-1:0] pg_lo_lim = vset_w * pg_lo_pct;
	wire [fault_sup_pkg::PROD_W-1:0] pg_hi_lim = vset_w * fault_sup_pkg::PG_HI_PCT;

	// low setpoints would put the overvoltage limit under a volt; clamp it
	wire [fault_sup_pkg::PROD_W-1:0] ov_lim = (ov_pct_lim < fault_sup_pkg::OV_FLOOR_SCALED)
		? fault_sup_pkg::OV_FLOOR_SCALED : ov_pct_lim;

	// tracking error magnitude against the ramp target
	wire [fault_sup_pkg::MV_W-1:0] trk_err = (vout_mv >= ramp_target_mv)
		? vout_mv - ramp_target_mv : ramp_target_mv - vout_mv;

	// overtemperature recovery and warning hysteresis state
	logic ot_hot_q;
	logic [fault_sup_pkg::TEMP_W-1:0] warn_clr_c;
	assign warn_clr_c = fault_sup_pkg::WARN_SET_C - fault_sup_pkg::WARN_HYST_C;
	wire ot_cool = temp_c <= fault_sup_pkg::OT_RESTART_C;

	// raw conditions; undervoltage blanked during ramp since the output is still rising
	assign uv_c.raw = !ramping && (vout_x100 < uv_lim);
	assign ov_c.raw = vout_x100 > ov_lim;
	assign trk_c.raw = trk_en && ramping && (trk_err > fault_sup_pkg::TRK_BAND_MV);
	assign ot_c.raw = temp_c >= fault_sup_pkg::OT_TRIP_C;
	assign warn_c.raw = warn_c.level ? (temp_c > warn_clr_c)
		: (temp_c > fault_sup_pkg::WARN_SET_C);
	assign pg_c.raw = (vout_x100 >= pg_lo_lim) && (vout_x100 <= pg_hi_lim);

	// six microsecond qualifiers
	cond_qualifier #(.DELAY_CYC(fault_sup_pkg::TRIP_CYC)) uv_q_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.q(uv_c.filt)
	);
	cond_qualifier #(.DELAY_CYC(fault_sup_pkg::TRIP_CYC)) ov_q_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.q(ov_c.filt)
	);
	cond_qualifier #(.DELAY_CYC(fault_sup_pkg::TRIP_CYC)) trk_q_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.q(trk_c.filt)
	);
	cond_qualifier #(.DELAY_CYC(fault_sup_pkg::TRIP_CYC)) warn_q_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.q(warn_c.filt)
	);
	cond_qualifier #(.DELAY_CYC(fault_sup_pkg::TRIP_CYC)) pg_q_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.q(pg_c.filt)
	);
	// two millisecond overtemperature qualifier
	cond_qualifier #(.DELAY_CYC(OT_DELAY_CYC)) ot_q_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.q(ot_c.filt)
	);

	// qualified fault events and whether each wants to latch
	wire uv_ev = uv_c.level;
	wire ov_ev = ov_c.level;
	wire trk_ev = trk_c.level;
	wire ot_ev = ot_c.level;
	wire any_ev = uv_ev || ov_ev || trk_ev || ot_ev;
	wire latch_ev = (uv_ev && uv_latch_en) || (ot_ev && ot_latch_en)
		|| (ov_ev && ov_latch_en) || (trk_ev && trk_latch_en);

	fault_sup_pkg::sup_state_t state_q;
	fault_sup_pkg::sup_state_t state_d;
	logic [RETRY_W-1:0] retry_cnt_q;
	wire retry_done = retry_cnt_q == RETRY_LAST;
	// overtemperature blocks release until the die cools to the restart level
	wire release_ok = !ot_hot_q || ot_cool;

	// supervisor sequence; a latching fault arriving with the clear keeps the latch set
	always_comb begin
		state_d = state_q;
		case (state_q)
			fault_sup_pkg::ST_RUN: begin
				if (latch_ev) begin
					state_d = fault_sup_pkg::ST_LATCHED;
				end else if (any_ev) begin
					state_d = fault_sup_pkg::ST_RETRY;
				end
			end
			fault_sup_pkg::ST_RETRY: begin
				if (latch_ev) begin
					state_d = fault_sup_pkg::ST_LATCHED;
				end else if (retry_done && release_ok) begin
					state_d = fault_sup_pkg::ST_RUN;
				end
			end
			fault_sup_pkg::ST_LATCHED: begin
				if (fault_clear && !latch_ev && release_ok) begin
					state_d = fault_sup_pkg::ST_RUN;
				end
			end
			default: begin
				state_d = fault_sup_pkg::ST_LATCHED;
			end
		endcase
	end

	// state register and retry period counter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= fault_sup_pkg::ST_RUN;
			retry_cnt_q <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			retry_cnt_q <= (state_q == fault_sup_pkg::ST_RETRY && !retry_done)
				? retry_cnt_q + 1'b1 : '0;
		end
	end

	// overtemperature shutdown memory, set on trip, cleared only when cool
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ot_hot_q <= 1'b0;
		end else if (clk_en) begin
			if (ot_ev) begin
				ot_hot_q <= 1'b1;
			end else if (ot_cool) begin
				ot_hot_q <= 1'b0;
			end
		end
	end

	// registered outputs; turn-off follows the next state so no extra cycle is added
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			turn_off <= 1'b0;
			ot_warning <= 1'b0;
			power_good_out <= 1'b0;
			undervoltage_trip <= 1'b0;
			overvoltage_trip <= 1'b0;
			tracking_trip <= 1'b0;
			ot_trip <= 1'b0;
			fault_latched <= 1'b0;
		end else if (clk_en) begin
			turn_off <= state_d != fault_sup_pkg::ST_RUN;
			ot_warning <= warn_c.level;
			power_good_out <= pg_c.level;
			undervoltage_trip <= uv_ev;
			overvoltage_trip <= ov_ev;
			tracking_trip <= trk_ev;
			ot_trip <= ot_ev;
			fault_latched <= state_d == fault_sup_pkg::ST_LATCHED;
		end
	end
endmodule
`default_nettype wire

/* File: common/fault_sup_pkg.sv */
// constants shared by the output fault supervisor and its qualifier filter
// assumes a 50 MHz core clock and millivolt / degree-celsius measurement words
`default_nettype none
package fault_sup_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int unsigned MV_W = 12;
	localparam int unsigned TEMP_W = 8;
	localparam int unsigned PROD_W = 20;
	// qualification and retry delays in their own units
	localparam int unsigned TRIP_DELAY_US = 6;
	localparam int unsigned OT_DELAY_MS = 2;
	localparam int unsigned RETRY_PERIOD_MS = 130;
	localparam int unsigned TRIP_CYC = TRIP_DELAY_US * CLK_MHZ;
	localparam int unsigned OT_CYC = OT_DELAY_MS * 1000 * CLK_MHZ;
	localparam int unsigned RETRY_CYC = RETRY_PERIOD_MS * 1000 * CLK_MHZ;
	// undervoltage fraction: base plus step per select code, capped at max
	localparam logic [7:0] UV_PCT_BASE = 8'd75;
	localparam logic [7:0] UV_PCT_STEP = 8'd5;
	// power-good window
	localparam logic [7:0] PG_LO_PCT_BASE = 8'd90;
	localparam logic [7:0] PG_LO_PCT_STEP = 8'd5;
	localparam logic [7:0] PG_HI_PCT = 8'd110;
	// overvoltage fraction and absolute floor
	localparam logic [7:0] OV_PCT_BASE = 8'd110;
	localparam logic [7:0] OV_PCT_STEP = 8'd10;
	localparam logic [7:0] OV_PCT_MAX = 8'd130;
	localparam logic [PROD_W-1:0] OV_FLOOR_SCALED = 20'd100_000; // 1000 mV times 100
	localparam logic [7:0] PCT_SCALE = 8'd100;
	// tracking error band
	localparam logic [MV_W-1:0] TRK_BAND_MV = 12'd250;
	// temperatures
	localparam logic [TEMP_W-1:0] OT_TRIP_C = 8'd120;
	localparam logic [TEMP_W-1:0] OT_RESTART_C = 8'd110;
	localparam logic [TEMP_W-1:0] WARN_SET_C = 8'd120;
	localparam logic [TEMP_W-1:0] WARN_HYST_C = 8'd3;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_RETRY = 2'b01,
		ST_LATCHED = 2'b10
	} sup_state_t;
endpackage
`default_nettype wire

/* File: common/qual_if.sv */
// carrier between the supervisor and one condition qualifier
// raw condition goes in, the time-qualified level comes back
`default_nettype none
interface qual_if;
	logic raw;
	logic level;
	modport filt (input raw, output level);
	modport user (output raw, input level);
endinterface
`default_nettype wire

/* File: core/cond_qualifier.sv */
// time qualifier: output follows the raw condition once it has held steady
// for DELAY_CYC consecutive enabled clocks; assumes synchronous raw input
`default_nettype none
module cond_qualifier #(
	parameter int unsigned DELAY_CYC = 300
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	qual_if.filt q
);
	localparam int unsigned CNT_W = $clog2(DELAY_CYC + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY_CYC - 1);
	logic [CNT_W-1:0] cnt_q;
	logic level_q;
	wire differs = q.raw != level_q;
	wire done = differs && (cnt_q == LAST);
	// a short glitch restarts the count, so only a held crossing moves the output
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_q <= '0;
			level_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= (differs && !done) ? cnt_q + 1'b1 : '0;
			if (done) begin
				level_q <= q.raw;
			end
		end
	end
	assign q.level = level_q;
endmodule
`default_nettype wire

/* File: verif/fault_sup_asserts.sv */
// assertions for the output fault supervisor, seen from its top ports only
// assumes one clock domain, synchronous active-high reset, clk_en held high
`default_nettype none
module fault_sup_asserts (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [fault_sup_pkg::MV_W-1:0] vout_mv,
	input wire logic [fault_sup_pkg::MV_W-1:0] vset_mv,
	input wire logic [fault_sup_pkg::TEMP_W-1:0] temp_c,
	input wire logic pg_lo_sel,
	input wire logic trk_en,
	input wire logic fault_clear,
	input wire logic turn_off,
	input wire logic ot_warning,
	input wire logic power_good_out,
	input wire logic undervoltage_trip,
	input wire logic overvoltage_trip,
	input wire logic tracking_trip,
	input wire logic ot_trip,
	input wire logic fault_latched
);
	// raw window test, scaled by 100 so no division is needed
	wire logic [23:0] v100 = 24'(vout_mv) * 24'h64;
	wire logic [23:0] lo = 24'(vset_mv) * (pg_lo_sel ? 24'h5f : 24'h5a);
	wire logic in_win = v100 >= lo && v100 <= 24'(vset_mv) * 24'h6e;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// $past depth 2: qualifier edge plus the output register
	property p_uv; $rose(undervoltage_trip) |-> turn_off; endproperty
	property p_trk; $rose(tracking_trip) |-> turn_off && $past(trk_en, 2); endproperty
	property p_ot; $rose(ot_trip) |-> turn_off && $past(temp_c, 2) >= 8'h78; endproperty
	property p_hot; turn_off && ot_trip && temp_c > 8'h6e |=> turn_off; endproperty
	property p_wset; $rose(ot_warning) |-> $past(temp_c, 2) > 8'h78; endproperty
	property p_wclr; $fell(ot_warning) |-> $past(temp_c, 2) <= 8'h75; endproperty
	property p_pg; $rose(power_good_out) |-> $past(in_win, 2); endproperty
	property p_ov; $rose(overvoltage_trip) |-> $past(vout_mv, 2) > 12'h3e8; endproperty
	property p_lat; fault_latched && !fault_clear |=> fault_latched; endproperty
	a_uv: assert property (p_uv) else $error("uv trip without turn-off");
	a_trk: assert property (p_trk) else $error("tracking trip while disabled");
	a_ot: assert property (p_ot) else $error("ot trip below threshold");
	a_hot: assert property (p_hot) else $error("restart while still hot");
	a_wset: assert property (p_wset) else $error("warning set too cool");
	a_wclr: assert property (p_wclr) else $error("warning cleared too hot");
	a_pg: assert property (p_pg) else $error("power good outside window");
	a_ov: assert property (p_ov) else $error("ov trip under floor");
	a_lat: assert property (p_lat) else $error("latch dropped without clear");
	c_pg: cover property ($rose(power_good_out));
	c_ot: cover property ($rose(ot_trip));
	c_rel: cover property ($fell(turn_off));
endmodule
bind output_fault_supervisor fault_sup_asserts u_chk (
	.ref_clk(ref_clk), .srst(srst), .vout_mv(vout_mv), .vset_mv(vset_mv),
	.temp_c(temp_c), .pg_lo_sel(pg_lo_sel), .trk_en(trk_en), .fault_clear(fault_clear),
	.turn_off(turn_off), .ot_warning(ot_warning), .power_good_out(power_good_out),
	.undervoltage_trip(undervoltage_trip), .overvoltage_trip(overvoltage_trip),
	.tracking_trip(tracking_trip), .ot_trip(ot_trip), .fault_latched(fault_latched)
);
`default_nettype wire

/* File: verif/testbench.sv */
// bench for the output fault supervisor: random setpoints plus corner cases
// assumes the package is compiled first and the checker binds to the dut
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, srst, clk_en, ramping, pg_lo_sel, fault_clear, uv_latch_en;
	logic ot_latch_en, ov_latch_en, trk_en, trk_latch_en;
	logic [1:0] uv_pct_sel, ov_pct_sel;
	logic [fault_sup_pkg::MV_W-1:0] vout_mv, vset_mv, ramp_target_mv;
	logic [fault_sup_pkg::TEMP_W-1:0] temp_c;
	wire logic turn_off, ot_warning, power_good_out, undervoltage_trip;
	wire logic overvoltage_trip, tracking_trip, ot_trip, fault_latched;
	int errors, cmp_count, seed, p, l;
	// outputs by index: 0 off, 1 warn, 2 pg, 3 uv, 4 ov, 5 trk, 6 ot, 7 latched
	wire logic [7:0] o = {fault_latched, ot_trip, tracking_trip, overvoltage_trip,
		undervoltage_trip, power_good_out, ot_warning, turn_off};
	// short delays keep the run small; figures below derive from them
	output_fault_supervisor #(.OT_DELAY_CYC(20), .RETRY_DELAY_CYC(50)) dut (
		.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .vout_mv(vout_mv),
		.vset_mv(vset_mv), .ramp_target_mv(ramp_target_mv), .ramping(ramping),
		.temp_c(temp_c), .uv_pct_sel(uv_pct_sel), .ov_pct_sel(ov_pct_sel),
		.pg_lo_sel(pg_lo_sel), .uv_latch_en(uv_latch_en), .ot_latch_en(ot_latch_en),
		.ov_latch_en(ov_latch_en), .trk_en(trk_en), .trk_latch_en(trk_latch_en),
		.fault_clear(fault_clear), .turn_off(turn_off), .ot_warning(ot_warning),
		.power_good_out(power_good_out), .undervoltage_trip(undervoltage_trip),
		.overvoltage_trip(overvoltage_trip), .tracking_trip(tracking_trip),
		.ot_trip(ot_trip), .fault_latched(fault_latched));
	// 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// smallest voltage that is not below pct percent of the setpoint
	function int ceil_pct(input int s, input int pct);
		return (s * pct + 99) / 100;
	endfunction
	task chk(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// output i must keep its old value until exactly edge n after the drive
	task st(input int n, input int i, input logic e);
		cyc(n - 1);
		chk(o[i], !e);
		cyc(1);
		chk(o[i], e);
	endtask
	task drv(input int v);
		@(posedge ref_clk);
		vout_mv <= v[11:0];
	endtask
	// return to a healthy steady state and clear any latch
	task settle;
		@(posedge ref_clk);
		vout_mv <= vset_mv;
		ramp_target_mv <= vset_mv;
		temp_c <= 8'h19;
		ramping <= 1'b0;
		trk_en <= 1'b0;
		cyc(700);
		fault_clear <= 1'b1;
		cyc(1);
		fault_clear <= 1'b0;
		cyc(60);
		chk(turn_off, 1'b0);
	endtask
	task final_report;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence; ot and ov latching stay at their defaults
	initial begin
		seed = 1;
		errors = 0;
		cmp_count = 0;
		{srst, clk_en} = 2'h3;
		{ramping, pg_lo_sel, fault_clear, uv_latch_en, ot_latch_en} = 5'h00;
		{ov_latch_en, trk_en, trk_latch_en, uv_pct_sel} = 5'h00;
		ov_pct_sel = 2'h2;
		temp_c = 8'h19;
		{vset_mv, vout_mv, ramp_target_mv} = {3{12'h4b0}};
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		settle;
		// window edges for both lower bounds, random setpoint
		for (int s = 0; s < 2; s++) begin
			@(posedge ref_clk);
			vset_mv <= 12'h3e8 + 12'({$random(seed)} % 2000);
			pg_lo_sel <= s[0];
			settle;
			p = ceil_pct(int'(vset_mv), 90 + 5 * s);
			drv(p - 1); st(301, 2, 1'b0);
			drv(p); st(301, 2, 1'b1);
			drv(int'(vset_mv) * 110 / 100 + 1); st(301, 2, 1'b0);
			drv(int'(vset_mv) * 110 / 100); st(301, 2, 1'b1);
		end
		// dips shorter than the qualification time are ignored
		for (int g = 0; g < 2; g++) begin
			l = g ? 298 : 1 + {$random(seed)} % 200;
			drv(0); cyc(l); drv(int'(vset_mv)); cyc(400);
			chk(o[3], 1'b0);
		end
		// every undervoltage fraction, odd codes latching
		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk);
			uv_pct_sel <= s[1:0];
			uv_latch_en <= s[0];
			p = ceil_pct(int'(vset_mv), 75 + 5 * s);
			drv(p); cyc(400); chk(o[3], 1'b0);
			drv(p - 1); st(301, 3, 1'b1);
			chk(turn_off, 1'b1);
			if (s[0]) begin
				cyc(60); chk(fault_latched & turn_off, 1'b1);
			end else begin
				st(50, 0, 1'b0);
				cyc(1); chk(turn_off, 1'b1);
			end
			settle;
		end
		// overtemperature shutdown, warning hysteresis, cool-down restart
		@(posedge ref_clk) temp_c <= 8'h78;
		st(21, 6, 1'b1); chk(turn_off, 1'b1);
		@(posedge ref_clk) temp_c <= 8'h79;
		st(301, 1, 1'b1);
		@(posedge ref_clk) temp_c <= 8'h76;
		cyc(400); chk(ot_warning, 1'b1);
		@(posedge ref_clk) temp_c <= 8'h75;
		st(301, 1, 1'b0);
		@(posedge ref_clk) temp_c <= 8'h6f;
		cyc(200); chk(turn_off, 1'b1);
		@(posedge ref_clk) temp_c <= 8'h6e;
		cyc(60); chk(turn_off, 1'b0);
		settle;
		// tracking: off by default, 250 mV allowed, 251 mV trips and latches
		@(posedge ref_clk);
		ramping <= 1'b1;
		ramp_target_mv <= vset_mv + 12'h12c;
		cyc(400); chk(o[5], 1'b0);
		{trk_en, trk_latch_en} <= 2'h3;
		ramp_target_mv <= vset_mv + 12'h0fa;
		cyc(400); chk(o[5], 1'b0);
		@(posedge ref_clk) ramp_target_mv <= vset_mv - 12'h0fb;
		st(301, 5, 1'b1); chk(fault_latched, 1'b1);
		settle;
		// low setpoint: overvoltage limit held at the 1000 mV floor
		@(posedge ref_clk);
		vset_mv <= 12'h320;
		ov_pct_sel <= 2'h0;
		settle;
		drv(1000); cyc(400); chk(o[4], 1'b0);
		drv(1001); st(301, 4, 1'b1);
		settle;
		final_report;
	end
endmodule
`default_nettype wire
